// *** rtl/oer_ep_if.sv ***
`timescale 1ns/1ps
interface oer_ep_if;
  logic [31:0] ctrl;
  logic [31:0] base;
  logic base_wr;
  logic [31:0] list_ptr;
  logic ptr_clear;
  logic loaded;
  logic stall;
  logic valid;
  logic [10:0] payload_bytes;
  logic [7:0] interval;
  modport core(output ctrl, output base, output base_wr, output ptr_clear, input list_ptr,
    input loaded, input stall, input valid, input payload_bytes, input interval);
  modport ep(input ctrl, input base, input base_wr, input ptr_clear, output list_ptr,
    output loaded, output stall, output valid, output payload_bytes, output interval);
endinterface

// *** rtl/oer_ep_track.sv ***
`timescale 1ns/1ps
module oer_ep_track (
  input wire logic mclk_in,
  input wire logic rst_in,
  oer_ep_if.ep ep
);
  import oer_pkg::*;
  typedef struct packed {
    logic [31:0] ptr;
    logic loaded;
  } oer_trk_s;
  oer_trk_s st_reg;
  oer_trk_s st_next;

  always_comb begin
    st_next = st_reg;
    st_next.loaded = 1'b0;
    if (ep.ptr_clear) begin
      st_next.ptr = 32'h00000000;
    end
    // hand-off only into an empty internal pointer, else leave the request pending
    if (ep.base[PTR_READY_BIT] && (st_reg.ptr == 32'h00000000) && !ep.base_wr) begin // R9
      st_next.ptr = ep.base & DESC_PTR_MASK; // R8
      st_next.loaded = 1'b1;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign ep.list_ptr = st_reg.ptr;
  assign ep.loaded = st_reg.loaded;
  assign ep.valid = ep.ctrl[EP_ENABLE_BIT]; // R1
  assign ep.stall = ep.ctrl[EP_ENABLE_BIT] & ep.ctrl[EP_HALT_BIT]; // R3
  assign ep.interval = ep.ctrl[EP_INTERVAL_HI:EP_INTERVAL_LO]; // R2
  assign ep.payload_bytes = 11'(11'h008 << ep.ctrl[EP_PAYLOAD_HI:EP_PAYLOAD_LO]); // R4
endmodule

// *** rtl/oer_pkg.sv ***
package oer_pkg;
  localparam int unsigned ADDR_W = 6;
  // register byte offsets on the wishbone port
  localparam logic [5:0] OFS_INT_IN_CTRL = 6'h00;
  localparam logic [5:0] OFS_INT_IN_DESC_BASE = 6'h04;
  localparam logic [5:0] OFS_BULK_IN_TWO_CTRL = 6'h08;
  localparam logic [5:0] OFS_BULK_IN_TWO_DESC_BASE = 6'h0c;
  localparam logic [5:0] OFS_BULK_OUT_THREE_CTRL = 6'h10;
  localparam logic [5:0] OFS_BULK_OUT_THREE_DESC_BASE = 6'h14;
  localparam logic [5:0] OFS_ENDPOINT_DESCRIPTOR_TALLY = 6'h18;
  localparam logic [5:0] OFS_DUAL_ROLE_CONTROL = 6'h1c;
  localparam logic [5:0] OFS_DUAL_ROLE_IRQ_ENABLE = 6'h20;
  localparam logic [5:0] OFS_DUAL_ROLE_IRQ_STATUS = 6'h24;
  // endpoint control fields
  localparam int unsigned EP_ENABLE_BIT = 31;
  localparam int unsigned EP_INTERVAL_HI = 30;
  localparam int unsigned EP_INTERVAL_LO = 23;
  localparam int unsigned EP_HALT_BIT = 13;
  localparam int unsigned EP_PAYLOAD_HI = 12;
  localparam int unsigned EP_PAYLOAD_LO = 10;
  localparam int unsigned EP_DIR_BIT = 9;
  localparam int unsigned EP_NUM_HI = 8;
  localparam int unsigned EP_NUM_LO = 5;
  localparam int unsigned EP_TYPE_HI = 2;
  localparam logic [2:0] PAYLOAD_RST_EP01 = 3'b011;
  localparam logic [2:0] PAYLOAD_RST_EP25 = 3'b110;
  // control mask: enable, interval, halt, payload, number, type
  localparam logic [31:0] EP_CTRL_WMASK = 32'hff803de7;
  // descriptor base and tally fields
  localparam int unsigned PTR_READY_BIT = 0;
  localparam logic [31:0] DESC_PTR_MASK = 32'hfffffffc;
  localparam int unsigned PENDING_BIT = 8;
  localparam logic [4:0] TALLY_RST = 5'b00000;
  // dual role control
  localparam int unsigned CTL_PWR_OFF = 0;
  localparam int unsigned CTL_PWR_REQ = 1;
  localparam int unsigned CTL_SWAP_GRANT = 2;
  localparam int unsigned CTL_SWAP_ALLOW = 4;
  localparam int unsigned CTL_WANTS_LINK = 5;
  localparam int unsigned CTL_SRP_WATCH = 6;
  localparam int unsigned CTL_SUSP_WATCH = 8;
  localparam logic [31:0] CTL_WMASK = 32'h0000017f;
  localparam logic [31:0] CTL_RST = 32'h00000040;
  // irq enable and status
  localparam int unsigned IRQ_EVENTS = 18;
  localparam int unsigned ST_ID_RISE = 17;
  localparam int unsigned ST_A_ATTACH = 16;
  localparam int unsigned ST_B_ATTACH = 15;
  localparam int unsigned ST_PERIPH = 28;
  localparam int unsigned ST_HOST = 29;
  localparam int unsigned ST_ID_LEVEL = 30;
  localparam int unsigned ST_ID_SETTLED = 31;
  localparam int unsigned EP_COUNT = 3;
endpackage

// *** rtl/oer_regs.sv ***
// Our own choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
// Operation
// (R1) endpoint works only while enable bit set
// (R2) bits 30:23 give polling interval
// (R3) halt bit forces stall on every request; code stalls only while enable bit set, and only on the two bulk endpoints
// (R4) payload code decodes to 8..1024 bytes
// (R5) payload resets 64 for ep0/1, 512 others
// (R6) number, type writable; direction bit read-only
// (R7) interrupt endpoint base pointer full 32 bits
// (R8) bulk base holds aligned list pointer
// (R9) ready bit loads null pointer, then clears
// (R10) software sets ready after descriptors prepared
// (R11) control tally: software adds, device subtracts
// (R12) pending flag: software sets, device clears
// (R13) power-off bit removes bus power
// (R14) power-request bit applies bus power
// (R15) software sets swap grant with peer
// (R16) swap allowed only on direct capable port
// (R17) software holds link request while needed
// (R18) session-request watch resets on, gates detection
// (R19) suspend watch gates suspend detection
// (R20) eighteen event enables, upper bits reserved
// (R21) status top bits show id and role
// (R22) id rise and attach events latch
// (R23) write one clears latched status bit
// (R24) irq when latched bit and enable both set
module oer_regs (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [oer_pkg::ADDR_W-1:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic id_settled_in,
  input wire logic id_level_in,
  input wire logic acting_as_host_in,
  input wire logic acting_as_peripheral_in,
  input wire logic a_attach_in,
  input wire logic b_attach_in,
  input wire logic srp_seen_in,
  input wire logic suspend_seen_in,
  input wire logic [1:0] ep_request_in,
  input wire logic ctrl_consume_in,
  input wire logic int_in_done_in,
  input wire logic [1:0] list_done_in,
  output logic wb_ack_out,
  output logic [31:0] wb_dat_out,
  output logic [1:0] ep_stall_out,
  output logic [1:0] ep_valid_out,
  output logic [31:0] bulk_in_list_ptr_out,
  output logic [31:0] bulk_out_list_ptr_out,
  output logic [31:0] int_in_base_out,
  output logic int_in_pending_out,
  output logic [4:0] ctrl_descriptor_tally_out,
  output logic bus_power_out,
  output logic srp_detect_out,
  output logic suspend_detect_out,
  output logic irq_out
);
  import oer_pkg::*;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [31:0] int_in_ctrl;
    logic [31:0] int_in_desc_base;
    logic [31:0] bulk_in_two_ctrl;
    logic [31:0] bulk_in_two_desc_base;
    logic [31:0] bulk_out_three_ctrl;
    logic [31:0] bulk_out_three_desc_base;
    logic [4:0] ctrl_descriptor_tally;
    logic int_in_pending;
    logic [31:0] dual_role_control;
    logic [IRQ_EVENTS-1:0] dual_role_irq_enable;
    logic [IRQ_EVENTS-1:0] latched;
    logic id_level_q;
    logic power;
    logic srp_det;
    logic susp_det;
    logic irq;
    logic [1:0] stall;
    logic [1:0] valid;
    logic [31:0] in_ptr;
    logic [31:0] out_ptr;
  } oer_st_s;

  oer_st_s st_reg;
  oer_st_s st_next;

  oer_ep_if ep_if[2] ();
  logic [31:0] ep_ctrl_v[2];
  logic [31:0] ep_base_v[2];
  logic [1:0] base_wr;
  logic [1:0] loaded;

  assign ep_ctrl_v[0] = st_reg.bulk_in_two_ctrl;
  assign ep_ctrl_v[1] = st_reg.bulk_out_three_ctrl;
  assign ep_base_v[0] = st_reg.bulk_in_two_desc_base;
  assign ep_base_v[1] = st_reg.bulk_out_three_desc_base;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ep
      assign ep_if[gi].ctrl = ep_ctrl_v[gi];
      assign ep_if[gi].base = ep_base_v[gi];
      assign ep_if[gi].base_wr = base_wr[gi];
      assign ep_if[gi].ptr_clear = list_done_in[gi];
      assign loaded[gi] = ep_if[gi].loaded;
      oer_ep_track u_trk (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .ep(ep_if[gi])
      );
    end
  endgenerate

  logic wr_go;
  logic rd_go;
  logic [31:0] bmask;
  logic [IRQ_EVENTS-1:0] events;
  logic [31:0] status_word;

  assign wr_go = wb_cyc_in & wb_stb_in & wb_we_in & ~st_reg.ack;
  assign rd_go = wb_cyc_in & wb_stb_in & ~wb_we_in & ~st_reg.ack;
  assign bmask = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
  assign base_wr[0] = wr_go && (wb_adr_in == OFS_BULK_IN_TWO_DESC_BASE);
  assign base_wr[1] = wr_go && (wb_adr_in == OFS_BULK_OUT_THREE_DESC_BASE);

  always_comb begin
    events = '0;
    events[ST_A_ATTACH] = a_attach_in; // R22
    events[ST_B_ATTACH] = b_attach_in; // R22
    events[ST_ID_RISE] = id_level_in & ~st_reg.id_level_q; // R22
  end

  always_comb begin
    status_word = 32'h00000000;
    status_word[ST_ID_SETTLED] = id_settled_in; // R21
    status_word[ST_ID_LEVEL] = id_level_in; // R21
    status_word[ST_HOST] = acting_as_host_in; // R21
    status_word[ST_PERIPH] = acting_as_peripheral_in; // R21
    status_word[IRQ_EVENTS-1:0] = st_reg.latched;
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  always_comb begin
    st_next = st_reg;
    st_next.ack = wb_cyc_in & wb_stb_in & ~st_reg.ack;
    st_next.rdata = 32'h00000000;
    if (rd_go) begin
      case (wb_adr_in)
        OFS_INT_IN_CTRL: st_next.rdata = st_reg.int_in_ctrl;
        OFS_INT_IN_DESC_BASE: st_next.rdata = st_reg.int_in_desc_base;
        OFS_BULK_IN_TWO_CTRL: st_next.rdata = st_reg.bulk_in_two_ctrl;
        OFS_BULK_IN_TWO_DESC_BASE: st_next.rdata = st_reg.bulk_in_two_desc_base;
        OFS_BULK_OUT_THREE_CTRL: st_next.rdata = st_reg.bulk_out_three_ctrl;
        OFS_BULK_OUT_THREE_DESC_BASE: st_next.rdata = st_reg.bulk_out_three_desc_base;
        OFS_ENDPOINT_DESCRIPTOR_TALLY: begin
          st_next.rdata[4:0] = st_reg.ctrl_descriptor_tally;
          st_next.rdata[PENDING_BIT] = st_reg.int_in_pending;
        end
        OFS_DUAL_ROLE_CONTROL: st_next.rdata = st_reg.dual_role_control;
        OFS_DUAL_ROLE_IRQ_ENABLE: st_next.rdata[IRQ_EVENTS-1:0] = st_reg.dual_role_irq_enable;
        OFS_DUAL_ROLE_IRQ_STATUS: st_next.rdata = status_word;
        default: st_next.rdata = 32'h00000000;
      endcase
    end
    // hardware consumption first, so a software write in the same cycle lands on top
    if (ctrl_consume_in && (st_reg.ctrl_descriptor_tally != 5'h00)) begin
      st_next.ctrl_descriptor_tally = st_reg.ctrl_descriptor_tally - 5'h01; // R11
    end
    if (int_in_done_in) begin
      st_next.int_in_pending = 1'b0; // R12
    end
    if (loaded[0]) begin
      st_next.bulk_in_two_desc_base[PTR_READY_BIT] = 1'b0; // R9
    end
    if (loaded[1]) begin
      st_next.bulk_out_three_desc_base[PTR_READY_BIT] = 1'b0; // R9
    end
    if (wr_go) begin
      case (wb_adr_in)
        OFS_INT_IN_CTRL:
          st_next.int_in_ctrl = merge(st_reg.int_in_ctrl, wb_dat_in, bmask & EP_CTRL_WMASK); // R6
        OFS_INT_IN_DESC_BASE:
          st_next.int_in_desc_base = merge(st_reg.int_in_desc_base, wb_dat_in, bmask); // R7
        OFS_BULK_IN_TWO_CTRL:
          st_next.bulk_in_two_ctrl = merge(st_reg.bulk_in_two_ctrl, wb_dat_in,
                                           bmask & EP_CTRL_WMASK); // R6
        OFS_BULK_IN_TWO_DESC_BASE:
          st_next.bulk_in_two_desc_base = merge(st_reg.bulk_in_two_desc_base, wb_dat_in,
                                                bmask); // R8
        OFS_BULK_OUT_THREE_CTRL:
          st_next.bulk_out_three_ctrl = merge(st_reg.bulk_out_three_ctrl, wb_dat_in,
                                              bmask & EP_CTRL_WMASK); // R6
        OFS_BULK_OUT_THREE_DESC_BASE:
          st_next.bulk_out_three_desc_base = merge(st_reg.bulk_out_three_desc_base, wb_dat_in,
                                                   bmask); // R8
        OFS_ENDPOINT_DESCRIPTOR_TALLY: begin
          if (wb_sel_in[0]) begin
            st_next.ctrl_descriptor_tally = wb_dat_in[4:0]; // R11
          end
          if (wb_sel_in[1]) begin
            st_next.int_in_pending = wb_dat_in[PENDING_BIT]; // R12
          end
        end
        OFS_DUAL_ROLE_CONTROL:
          st_next.dual_role_control = merge(st_reg.dual_role_control, wb_dat_in,
                                            bmask & CTL_WMASK);
        OFS_DUAL_ROLE_IRQ_ENABLE:
          st_next.dual_role_irq_enable = IRQ_EVENTS'(merge(32'(st_reg.dual_role_irq_enable),
                                                           wb_dat_in, bmask)); // R20
        OFS_DUAL_ROLE_IRQ_STATUS:
          st_next.latched = st_reg.latched & ~IRQ_EVENTS'(wb_dat_in & bmask); // R23
        default: ;
      endcase
    end
    // set beats clear when both arrive together
    st_next.latched = st_next.latched | events; // R22
    st_next.id_level_q = id_level_in;
    // power-off overrides a pending power request
    if (st_reg.dual_role_control[CTL_PWR_OFF]) begin
      st_next.power = 1'b0; // R13
    end else if (st_reg.dual_role_control[CTL_PWR_REQ]) begin
      st_next.power = 1'b1; // R14
    end
    st_next.srp_det = st_reg.dual_role_control[CTL_SRP_WATCH] & srp_seen_in; // R18
    st_next.susp_det = st_reg.dual_role_control[CTL_SUSP_WATCH] & suspend_seen_in; // R19
    st_next.irq = |(st_reg.latched & st_reg.dual_role_irq_enable); // R24
    st_next.stall[0] = ep_if[0].stall & ep_request_in[0]; // R3
    st_next.stall[1] = ep_if[1].stall & ep_request_in[1]; // R3
    st_next.valid[0] = ep_if[0].valid; // R1
    st_next.valid[1] = ep_if[1].valid; // R1
    st_next.in_ptr = ep_if[0].list_ptr;
    st_next.out_ptr = ep_if[1].list_ptr;
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      st_reg <= '0;
      st_reg.int_in_ctrl[EP_PAYLOAD_HI:EP_PAYLOAD_LO] <= PAYLOAD_RST_EP01; // R5
      st_reg.int_in_ctrl[EP_DIR_BIT] <= 1'b1; // R6
      st_reg.bulk_in_two_ctrl[EP_PAYLOAD_HI:EP_PAYLOAD_LO] <= PAYLOAD_RST_EP25; // R5
      st_reg.bulk_in_two_ctrl[EP_DIR_BIT] <= 1'b1; // R6
      st_reg.bulk_out_three_ctrl[EP_PAYLOAD_HI:EP_PAYLOAD_LO] <= PAYLOAD_RST_EP25; // R5
      st_reg.dual_role_control <= CTL_RST; // R18
      st_reg.id_level_q <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign wb_ack_out = st_reg.ack;
  assign wb_dat_out = st_reg.rdata;
  assign ep_stall_out = st_reg.stall;
  assign ep_valid_out = st_reg.valid;
  assign bulk_in_list_ptr_out = st_reg.in_ptr;
  assign bulk_out_list_ptr_out = st_reg.out_ptr;
  assign int_in_base_out = st_reg.int_in_desc_base;
  assign int_in_pending_out = st_reg.int_in_pending;
  assign ctrl_descriptor_tally_out = st_reg.ctrl_descriptor_tally;
  assign bus_power_out = st_reg.power;
  assign srp_detect_out = st_reg.srp_det;
  assign suspend_detect_out = st_reg.susp_det;
  assign irq_out = st_reg.irq;
endmodule

// *** verification/oer_peer_model.sv ***
`timescale 1ns/1ps
module oer_peer_model (
  input wire logic mclk_in,
  output logic [7:0] lvl_out,
  output logic [5:0] ev_out
);
  initial begin
    lvl_out = 8'h00;
    ev_out = 6'h00;
  end
  // line levels move just after an edge, as the real detectors do
  task automatic set_lvl(input logic [7:0] v);
    @(posedge mclk_in);
    lvl_out <= v;
  endtask
  // events are single-cycle pulses
  task automatic fire(input logic [5:0] v);
    @(posedge mclk_in);
    ev_out <= v;
    @(posedge mclk_in);
    ev_out <= 6'h00;
  endtask
endmodule

// *** verification/oer_regs_monitor.sv ***
`timescale 1ns/1ps
module oer_regs_monitor (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic wb_ack_out,
  input wire logic [31:0] wb_dat_out,
  input wire logic [1:0] ep_request_in,
  input wire logic [1:0] ep_stall_out,
  input wire logic [1:0] ep_valid_out,
  input wire logic srp_seen_in,
  input wire logic srp_detect_out,
  input wire logic suspend_seen_in,
  input wire logic suspend_detect_out,
  input wire logic ctrl_consume_in,
  input wire logic [4:0] ctrl_descriptor_tally_out
);
  default clocking mon_cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);
  a_ack_follows: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("request not answered");
  a_ack_single: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  a_rdata_quiet: assert property (!(wb_ack_out && !wb_we_in) |-> wb_dat_out == 32'h0)
    else $error("read data outside read ack");
  a_stall_cause: assert property (ep_stall_out[0] |-> $past(ep_request_in[0]))
    else $error("stall without request");
  a_stall_enable: assert property (ep_stall_out[1] |-> ep_valid_out[1])
    else $error("stall on disabled endpoint");
  a_srp_gated: assert property (srp_detect_out |-> $past(srp_seen_in))
    else $error("session detect without cause");
  a_suspend_gated: assert property (suspend_detect_out |-> $past(suspend_seen_in))
    else $error("suspend detect without cause");
  // output is the tally register itself, so one cycle suffices; the window allows two
  a_tally_last: assert property (ctrl_consume_in && ctrl_descriptor_tally_out == 5'h01 &&
    !(wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out) |->
    ##[1:2] ctrl_descriptor_tally_out == 5'h00)
    else $error("tally not stepped down");
endmodule

// *** verification/otg_endpoint_and_control_regs_tb_top.sv ***
`timescale 1ns/1ps
module otg_endpoint_and_control_regs_tb_top;
  import oer_pkg::*;
  typedef struct packed {
    logic [5:0] adr;
    logic [31:0] wdat;
    logic [31:0] exp;
  } oer_row_s;
  logic mclk_in = 1'h0;
  logic rst_in;
  logic req;
  logic wb_we_in;
  logic [5:0] wb_adr_in;
  logic [3:0] wb_sel_in;
  logic [31:0] wb_dat_in;
  logic [31:0] rdat;
  logic [7:0] lvl;
  logic [5:0] ev;
  logic wb_ack_out, int_in_pending_out, bus_power_out, srp_detect_out, suspend_detect_out;
  logic irq_out;
  logic [31:0] wb_dat_out, bulk_in_list_ptr_out, bulk_out_list_ptr_out, int_in_base_out;
  logic [1:0] ep_stall_out, ep_valid_out;
  logic [4:0] ctrl_descriptor_tally_out;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  oer_row_s rows [11] = '{
    '{OFS_INT_IN_CTRL, 32'hffffffff, 32'hff803fe7},
    '{OFS_INT_IN_CTRL, 32'h0, 32'h00000200},
    '{OFS_BULK_IN_TWO_CTRL, 32'hffffffff, 32'hff803fe7},
    '{OFS_BULK_OUT_THREE_CTRL, 32'hffffffff, 32'hff803de7},
    '{OFS_BULK_OUT_THREE_CTRL, 32'h0, 32'h0},
    '{OFS_INT_IN_DESC_BASE, 32'ha5a5a5a5, 32'ha5a5a5a5},
    '{OFS_BULK_OUT_THREE_DESC_BASE, 32'h12345670, 32'h12345670},
    '{OFS_ENDPOINT_DESCRIPTOR_TALLY, 32'hffffffff, 32'h0000011f},
    '{OFS_DUAL_ROLE_IRQ_ENABLE, 32'hffffffff, 32'h0003ffff},
    '{OFS_DUAL_ROLE_CONTROL, 32'hffffffff, 32'h0000017f},
    '{6'h3c, 32'hffffffff, 32'h0}};
  oer_row_s rst_rows [7] = '{
    '{OFS_INT_IN_CTRL, 32'h0, 32'h00000e00},
    '{OFS_BULK_IN_TWO_CTRL, 32'h0, 32'h00001a00},
    '{OFS_BULK_OUT_THREE_CTRL, 32'h0, 32'h00001800},
    '{OFS_DUAL_ROLE_CONTROL, 32'h0, 32'h00000040},
    '{OFS_DUAL_ROLE_IRQ_ENABLE, 32'h0, 32'h0},
    '{OFS_INT_IN_DESC_BASE, 32'h0, 32'h0},
    '{OFS_DUAL_ROLE_IRQ_STATUS, 32'h0, 32'h0}};
  oer_regs DUT (
    .mclk_in, .rst_in, .wb_cyc_in(req), .wb_stb_in(req), .wb_we_in, .wb_adr_in, .wb_sel_in,
    .wb_dat_in, .id_settled_in(lvl[0]), .id_level_in(lvl[1]), .acting_as_host_in(lvl[2]),
    .acting_as_peripheral_in(lvl[3]), .srp_seen_in(lvl[4]), .suspend_seen_in(lvl[5]),
    .ep_request_in(lvl[7:6]), .a_attach_in(ev[0]), .b_attach_in(ev[1]),
    .ctrl_consume_in(ev[2]), .int_in_done_in(ev[3]), .list_done_in(ev[5:4]), .wb_ack_out,
    .wb_dat_out, .ep_stall_out, .ep_valid_out, .bulk_in_list_ptr_out, .bulk_out_list_ptr_out,
    .int_in_base_out, .int_in_pending_out, .ctrl_descriptor_tally_out, .bus_power_out,
    .srp_detect_out, .suspend_detect_out, .irq_out);
  oer_peer_model peer (.mclk_in(mclk_in), .lvl_out(lvl), .ev_out(ev));
  always #2.5 mclk_in = ~mclk_in;
  task automatic print_verdict();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // the bench watchdog alone bounds every wait
  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    req <= 1'h1;
    wb_we_in <= w;
    wb_adr_in <= a;
    wb_dat_in <= d;
    @(posedge mclk_in);
    while (wb_ack_out !== 1'h1) @(posedge mclk_in);
    rdat = wb_dat_out;
    req <= 1'h0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    xfer(1'h1, a, d);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] exp);
    xfer(1'h0, a, 32'h0);
    chk(rdat, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  initial begin
    rst_in <= 1'h1;
    req <= 1'h0;
    wb_we_in <= 1'h0;
    wb_adr_in <= 6'h00;
    wb_sel_in <= 4'hf;
    wb_dat_in <= 32'h0;
    tick(6);
    rst_in <= 1'h0;
    foreach (rows[i]) begin
      wr(rows[i].adr, rows[i].wdat);
      rd(rows[i].adr, rows[i].exp);
    end
    chk(int_in_base_out, 32'ha5a5a5a5);
    chk(bulk_out_list_ptr_out, 32'h0);
    rst_in <= 1'h1;
    tick(2);
    rst_in <= 1'h0;
    chk({int_in_pending_out, ctrl_descriptor_tally_out, bus_power_out}, 32'h0);
    foreach (rst_rows[i]) rd(rst_rows[i].adr, rst_rows[i].exp);
    wr(OFS_BULK_IN_TWO_DESC_BASE, 32'h00001005);
    tick(4);
    chk(bulk_in_list_ptr_out, 32'h00001004);
    rd(OFS_BULK_IN_TWO_DESC_BASE, 32'h00001004);
    wr(OFS_BULK_IN_TWO_DESC_BASE, 32'h00002009);
    tick(4);
    chk(bulk_in_list_ptr_out, 32'h00001004);
    peer.fire(6'h10);
    tick(4);
    chk(bulk_in_list_ptr_out, 32'h00002008);
    // out endpoint hand-off, then a list completion empties it with no reload
    wr(OFS_BULK_OUT_THREE_DESC_BASE, 32'h00003005);
    tick(4);
    chk(bulk_out_list_ptr_out, 32'h00003004);
    rd(OFS_BULK_OUT_THREE_DESC_BASE, 32'h00003004);
    peer.fire(6'h20);
    tick(4);
    chk(bulk_out_list_ptr_out, 32'h0);
    wr(OFS_BULK_OUT_THREE_CTRL, 32'h80002000);
    peer.set_lvl(8'h80);
    tick(2);
    chk({ep_stall_out, ep_valid_out}, 32'h0000000a);
    wr(OFS_BULK_OUT_THREE_CTRL, 32'h00002000);
    tick(2);
    chk({ep_stall_out, ep_valid_out}, 32'h0);
    wr(OFS_BULK_IN_TWO_CTRL, 32'h80002000);
    peer.set_lvl(8'h40);
    tick(2);
    chk({ep_stall_out, ep_valid_out}, 32'h00000005);
    wr(OFS_ENDPOINT_DESCRIPTOR_TALLY, 32'h00000102);
    tick(2);
    chk({int_in_pending_out, ctrl_descriptor_tally_out}, 32'h00000022);
    repeat (3) peer.fire(6'h04);
    peer.fire(6'h08);
    tick(2);
    chk({int_in_pending_out, ctrl_descriptor_tally_out}, 32'h0);
    wb_sel_in <= 4'he;
    wr(OFS_ENDPOINT_DESCRIPTOR_TALLY, 32'h0000001f);
    wb_sel_in <= 4'hf;
    rd(OFS_ENDPOINT_DESCRIPTOR_TALLY, 32'h0);
    wr(OFS_DUAL_ROLE_CONTROL, 32'h00000042);
    tick(2);
    chk(32'(bus_power_out), 32'h1);
    wr(OFS_DUAL_ROLE_CONTROL, 32'h00000043);
    tick(2);
    chk(32'(bus_power_out), 32'h0);
    peer.set_lvl(8'h30);
    tick(2);
    chk({srp_detect_out, suspend_detect_out}, 32'h2);
    wr(OFS_DUAL_ROLE_CONTROL, 32'h00000100);
    tick(2);
    chk({srp_detect_out, suspend_detect_out}, 32'h1);
    wr(OFS_DUAL_ROLE_IRQ_ENABLE, 32'h00010000);
    peer.set_lvl(8'h0f);
    peer.fire(6'h03);
    tick(2);
    chk(32'(irq_out), 32'h1);
    rd(OFS_DUAL_ROLE_IRQ_STATUS, 32'hf0038000);
    wr(OFS_DUAL_ROLE_IRQ_STATUS, 32'h0);
    rd(OFS_DUAL_ROLE_IRQ_STATUS, 32'hf0038000);
    wr(OFS_DUAL_ROLE_IRQ_STATUS, 32'h00010000);
    tick(2);
    chk(32'(irq_out), 32'h0);
    rd(OFS_DUAL_ROLE_IRQ_STATUS, 32'hf0028000);
    print_verdict();
  end
endmodule
bind oer_regs oer_regs_monitor mon (.mclk_in, .rst_in, .wb_cyc_in, .wb_stb_in, .wb_we_in,
  .wb_ack_out, .wb_dat_out, .ep_request_in, .ep_stall_out, .ep_valid_out, .srp_seen_in,
  .srp_detect_out, .suspend_seen_in, .suspend_detect_out, .ctrl_consume_in,
  .ctrl_descriptor_tally_out);
